// ### hdl/tmr_pkg.sv
// Constants for the 8-bit timer with one compare output
// Operation
// - Nonzero compare output mode routes compare output to pin; direction bit enables driver.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at TOP; 11 inverse; 01 reserved.
// - PWM with compare equal TOP and upper mode bit: only TOP action.
// - Phase correct: 10 clears on up match, sets on down match; 11 inverse.
// - Clock select 000 stop, 001 every clock, 010-101 divide 8/64/256/1024.
// - Clock select 110 counts falling, 111 rising edges of external input.
// - External edges count even when that pin is an output.
// - Counter register readable and writable, resets to zero.
// - Counter write suppresses compare match on the next timer tick.
// - Compare value continuously compared; match sets flag and drives waveform.
// - Compare interrupt enable bit 1 with global enable requests interrupt.
// - Overflow interrupt enable bit 0 with global enable requests interrupt.
// - Control: compare output mode bits 5:4, clock source bits 2:0.
// - Waveform mode: normal, phase correct, clear-on-match, fast PWM; PWM buffers compare.
// - Compare flag set on match; cleared by vector taken or writing one.
// - Overflow flag at overflow, or at 0x00 reversal in phase correct.
// - Force compare strobe applies action in non-PWM only, no irq, reads zero.
package tmr_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_CMP = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00C;
  localparam logic [11:0] ADDR_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_PINCFG = 12'h014;
  localparam int CTRL_FORCE = 7;
  localparam int CTRL_WGM0 = 6;
  localparam int CTRL_COM_HI = 5;
  localparam int CTRL_COM_LO = 4;
  localparam int CTRL_WGM1 = 3;
  localparam int CTRL_CS_HI = 2;
  localparam int FLAG_CMP = 1;
  localparam int FLAG_OVF = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRESC_W-1:0] DIV64_MASK = 10'h03F;
  localparam logic [PRESC_W-1:0] DIV256_MASK = 10'h0FF;
  localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3FF;
  typedef enum logic [1:0] {
    WM_NORMAL,
    WM_PHASE,
    WM_CTC,
    WM_FAST
  } tmr_wave_t;
  typedef enum logic [2:0] {
    CS_STOP,
    CS_DIV1,
    CS_DIV8,
    CS_DIV64,
    CS_DIV256,
    CS_DIV1024,
    CS_EXT_FALL,
    CS_EXT_RISE
  } tmr_clksel_t;
endpackage : tmr_pkg

// ### hdl/tmr_timer8.sv
// 8-bit timer with one compare output, APB register slave and interrupt
//
// The address map and the APB register port were left to the implementer.
module tmr_timer8
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  input wire logic globalIrqEnable,
  input wire logic cmpVectorTaken,
  input wire logic ovfVectorTaken,
  output logic irq,
  // Pins
  input wire logic externalCountInput,
  input wire logic portData,
  output logic compareOutputA,
  output logic compareOutputAOe_n
);
  logic [7:0] ctrl;
  logic [7:0] timerCount;
  logic [7:0] compareValueA;
  logic [7:0] cmpBuf;
  logic [7:0] timerIrqMask;
  logic [1:0] timerFlags;
  logic pinDirOut;
  logic waveOut;
  logic countDown;
  logic cntWritten;
  logic [PRESC_W-1:0] presc;
  logic extMeta;
  logic extSync;
  logic extPrev;
  logic tick;
  logic [1:0] comMode;
  tmr_wave_t waveMode;
  tmr_clksel_t clkSel;
  logic isPwm;
  logic [7:0] topVal;
  logic match;
  logic atTop;
  logic atBottom;
  logic ovfEvent;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic forceStrobe;
  logic [7:0] next_count;
  logic next_down;

  assign waveMode = tmr_wave_t'({ctrl[CTRL_WGM1], ctrl[CTRL_WGM0]});
  assign comMode = ctrl[CTRL_COM_HI:CTRL_COM_LO];
  assign clkSel = tmr_clksel_t'(ctrl[CTRL_CS_HI:0]);
  assign isPwm = (waveMode == WM_PHASE) || (waveMode == WM_FAST);
  assign topVal = (waveMode == WM_CTC) ? compareValueA : MAX_VAL;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign addrOk = (paddr == ADDR_CTRL) || (paddr == ADDR_COUNT) || (paddr == ADDR_CMP) ||
                  (paddr == ADDR_MASK) || (paddr == ADDR_FLAGS) || (paddr == ADDR_PINCFG);
  assign forceStrobe = wrEn && (paddr == ADDR_CTRL) && pwdata[CTRL_FORCE] && !isPwm;

  // Free-running shared-style prescaler
  always_ff @(posedge clk) begin
    if (srst) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      extMeta <= 1'b0;
      extSync <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extMeta <= externalCountInput;
      extSync <= extMeta;
      extPrev <= extSync;
    end
  end

  always_comb begin
    unique case (clkSel)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (presc & DIV8_MASK) == DIV8_MASK;
      CS_DIV64: tick = (presc & DIV64_MASK) == DIV64_MASK;
      CS_DIV256: tick = (presc & DIV256_MASK) == DIV256_MASK;
      CS_DIV1024: tick = (presc & DIV1024_MASK) == DIV1024_MASK;
      // External falling edge; pin direction ignored
      CS_EXT_FALL: tick = extPrev && !extSync;
      CS_EXT_RISE: tick = !extPrev && extSync;
    endcase
  end

  // Continuous compare, blocked after counter write
  assign match = tick && !cntWritten && (timerCount == cmpBuf);
  assign atTop = timerCount == topVal;
  assign atBottom = timerCount == BOTTOM_VAL;

  // Counter sequencing per waveform mode
  always_comb begin
    next_count = timerCount;
    next_down = countDown;
    ovfEvent = 1'b0;
    if (tick) begin
      unique case (waveMode)
        WM_PHASE: begin
          if (!countDown && timerCount == MAX_VAL) begin
            next_down = 1'b1;
            next_count = timerCount - 8'h01;
          end else if (countDown && atBottom) begin
            ovfEvent = 1'b1;
            next_down = 1'b0;
            next_count = timerCount + 8'h01;
          end else begin
            next_count = countDown ? timerCount - 8'h01 : timerCount + 8'h01;
          end
        end
        WM_CTC: begin
          next_down = 1'b0;
          next_count = atTop ? BOTTOM_VAL : timerCount + 8'h01;
          ovfEvent = timerCount == MAX_VAL;
        end
        default: begin
          next_down = 1'b0;
          next_count = timerCount + 8'h01;
          ovfEvent = timerCount == MAX_VAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timerCount <= COUNT_RESET;
      countDown <= 1'b0;
    end else if (wrEn && paddr == ADDR_COUNT) begin
      timerCount <= pwdata[7:0];
    end else begin
      timerCount <= next_count;
      countDown <= next_down;
    end
  end

  // Block match on next tick after a write
  always_ff @(posedge clk) begin
    if (srst) begin
      cntWritten <= 1'b0;
    end else if (wrEn && paddr == ADDR_COUNT) begin
      cntWritten <= 1'b1;
    end else if (tick) begin
      cntWritten <= 1'b0;
    end
  end

  // Control, compare, mask and pin direction registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
      compareValueA <= CMP_RESET;
      timerIrqMask <= MASK_RESET;
      pinDirOut <= 1'b0;
    end else if (wrEn) begin
      unique case (paddr)
        ADDR_CTRL: ctrl <= {1'b0, pwdata[6:0]};
        ADDR_CMP: compareValueA <= pwdata[7:0];
        ADDR_MASK: timerIrqMask <= pwdata[7:0];
        ADDR_PINCFG: pinDirOut <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Compare buffer: immediate in non-PWM, at TOP in PWM
  always_ff @(posedge clk) begin
    if (srst) begin
      cmpBuf <= CMP_RESET;
    end else if (!isPwm || (tick && atTop)) begin
      cmpBuf <= compareValueA;
    end
  end

  // Waveform generator
  always_ff @(posedge clk) begin
    if (srst) begin
      waveOut <= 1'b0;
    end else if (forceStrobe) begin
      unique case (comMode)
        2'b01: waveOut <= !waveOut;
        2'b10: waveOut <= 1'b0;
        2'b11: waveOut <= 1'b1;
        default: ;
      endcase
    end else if (tick) begin
      unique case (waveMode)
        WM_FAST: begin
          // Fast PWM; TOP action wins when compare equals TOP
          if (comMode[1] && atTop) begin
            waveOut <= !comMode[0];
          end else if (comMode[1] && match) begin
            waveOut <= comMode[0];
          end
        end
        WM_PHASE: begin
          // Up match clears for 10; compare at MAX keeps down-match level
          if (comMode[1] && cmpBuf == MAX_VAL && timerCount == MAX_VAL) begin
            waveOut <= !comMode[0];
          end else if (comMode[1] && match) begin
            waveOut <= countDown ? !comMode[0] : comMode[0];
          end
        end
        default: begin
          if (match) begin
            unique case (comMode)
              2'b01: waveOut <= !waveOut;
              2'b10: waveOut <= 1'b0;
              2'b11: waveOut <= 1'b1;
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      compareOutputA <= 1'b0;
      compareOutputAOe_n <= 1'b1;
    end else begin
      compareOutputA <= (comMode != 2'b00) ? waveOut : portData;
      compareOutputAOe_n <= !pinDirOut;
    end
  end

  // Sticky flags; set wins over any clear
  always_ff @(posedge clk) begin
    if (srst) begin
      timerFlags <= 2'b00;
    end else begin
      timerFlags[FLAG_CMP] <= match || (timerFlags[FLAG_CMP] && !cmpVectorTaken &&
                              !(wrEn && paddr == ADDR_FLAGS && pwdata[FLAG_CMP]));
      timerFlags[FLAG_OVF] <= ovfEvent || (timerFlags[FLAG_OVF] && !ovfVectorTaken &&
                              !(wrEn && paddr == ADDR_FLAGS && pwdata[FLAG_OVF]));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= globalIrqEnable && |(timerFlags & timerIrqMask[1:0]);
    end
  end

  // APB: read data captured in setup, ready in access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (rdEn) begin
        unique case (paddr)
          ADDR_CTRL: prdata <= {24'h000000, ctrl};
          ADDR_COUNT: prdata <= {24'h000000, timerCount};
          ADDR_CMP: prdata <= {24'h000000, compareValueA};
          ADDR_MASK: prdata <= {24'h000000, timerIrqMask};
          ADDR_FLAGS: prdata <= {30'h00000000, timerFlags};
          ADDR_PINCFG: prdata <= {31'h00000000, pinDirOut};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : tmr_timer8

// ### sim/test_timer8_compare_output_control.sv
// Self-checking bench for the 8-bit compare timer
module test_timer8_compare_output_control;
  import tmr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, errSeen;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, irq, externalCountInput, compareOutputA, compareOutputAOe_n, pinLevel;
  logic globalIrqEnable = 1'b0, cmpVectorTaken = 1'b0, ovfVectorTaken = 1'b0, portData = 1'b0;
  int n_errors = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  tmr_timer8 dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalIrqEnable(globalIrqEnable), .cmpVectorTaken(cmpVectorTaken),
    .ovfVectorTaken(ovfVectorTaken), .irq(irq), .externalCountInput(externalCountInput),
    .portData(portData), .compareOutputA(compareOutputA),
    .compareOutputAOe_n(compareOutputAOe_n));
  tmr_pin_model pm (.clk(clk), .compareOutputA(compareOutputA),
    .compareOutputAOe_n(compareOutputAOe_n), .externalCountInput(externalCountInput),
    .pinLevel(pinLevel));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(4 * i), '0);
      check(rdata, 32'h00000000);
      check(32'(errSeen), 32'(i == 6));
    end
    apb(1'b1, ADDR_COUNT, 32'hFFFFFF5A);
    apb(1'b0, ADDR_COUNT, '0);
    check(rdata, 32'h0000005A);
    apb(1'b1, ADDR_CMP, 32'h0000003C);
    apb(1'b0, ADDR_CMP, '0);
    check(rdata, 32'h0000003C);
  endtask : t_reset
  task automatic t_prescale();
    int divs[5] = '{1, 8, 64, 256, 1024};
    int e;
    for (int k = 0; k < 5; k++) begin
      e = (4 * divs[k] + 3) / divs[k];
      apb(1'b1, ADDR_COUNT, '0);
      apb(1'b1, ADDR_CTRL, 32'(k + 1));
      repeat (4 * divs[k]) @(posedge clk);
      apb(1'b1, ADDR_CTRL, '0);
      apb(1'b0, ADDR_COUNT, '0);
      check(32'(rdata >= e - 1 && rdata <= e + 1), 32'h1);
    end
    repeat (20) @(posedge clk);
    apb(1'b0, ADDR_COUNT, '0);
    check(32'(rdata >= e - 1 && rdata <= e + 1), 32'h1);
  endtask : t_prescale
  task automatic t_ext();
    apb(1'b1, ADDR_PINCFG, 32'h1);
    apb(1'b1, ADDR_COUNT, '0);
    for (int m = 7; m >= 6; m--) begin
      apb(1'b1, ADDR_CTRL, 32'(m));
      repeat (m - 4) pm.pulse();
      repeat (6) @(posedge clk);
      apb(1'b0, ADDR_COUNT, '0);
      check(rdata, 32'(m == 7 ? 3 : 5));
    end
  endtask : t_ext
  task automatic t_force();
    logic [7:0] modes[3] = '{8'h30, 8'h20, 8'h10};
    apb(1'b1, ADDR_CTRL, '0);
    apb(1'b1, ADDR_FLAGS, 32'h3);
    portData <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(compareOutputA), 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CTRL, {24'h0, modes[i]});
      apb(1'b1, ADDR_CTRL, {24'h0, modes[i] | 8'h80});
      repeat (2) @(posedge clk);
      check(32'({pinLevel, compareOutputAOe_n}), 32'(i == 1 ? 0 : 2));
      apb(1'b0, ADDR_CTRL, '0);
      check(rdata, 32'(modes[i]));
    end
    apb(1'b0, ADDR_FLAGS, '0);
    check(rdata, 32'h0);
  endtask : t_force
  task automatic t_irq();
    int n = 0;
    logic prev;
    apb(1'b1, ADDR_CMP, 32'h3);
    apb(1'b1, ADDR_MASK, 32'h2);
    globalIrqEnable <= 1'b1;
    apb(1'b1, ADDR_COUNT, '0);
    apb(1'b1, ADDR_CTRL, 32'h19);
    prev = compareOutputA;
    repeat (40) begin
      @(posedge clk);
      if (compareOutputA !== prev) n++;
      prev = compareOutputA;
    end
    check(32'(n >= 9 && n <= 11), 32'h1);
    apb(1'b1, ADDR_CTRL, '0);
    check(32'(irq), 32'h1);
    apb(1'b1, ADDR_FLAGS, 32'h2);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b1, ADDR_CMP, 32'hFF);
    apb(1'b1, ADDR_COUNT, 32'hFE);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CTRL, '0);
    @(posedge clk);
    check(32'(irq), 32'h1);
    ovfVectorTaken <= 1'b1;
    @(posedge clk);
    ovfVectorTaken <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    apb(1'b0, ADDR_FLAGS, '0);
    check(rdata, 32'h2);
    cmpVectorTaken <= 1'b1;
    @(posedge clk);
    cmpVectorTaken <= 1'b0;
    apb(1'b0, ADDR_FLAGS, '0);
    check(rdata, 32'h0);
    apb(1'b1, ADDR_CMP, 32'h10);
    apb(1'b1, ADDR_COUNT, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CTRL, '0);
    apb(1'b0, ADDR_FLAGS, '0);
    check(rdata, 32'h0);
  endtask : t_irq
  task automatic t_pwm();
    logic [7:0] ctl[6] = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h71, 8'h61};
    logic [7:0] cmp[6] = '{8'h80, 8'h80, 8'hFF, 8'h40, 8'h40, 8'hFF};
    int lo[6] = '{126, 125, 256, 125, 379, 510};
    int hi[6] = '{131, 130, 256, 131, 385, 510};
    int n;
    for (int i = 0; i < 6; i++) begin
      n = 0;
      apb(1'b1, ADDR_CMP, 32'(cmp[i]));
      apb(1'b1, ADDR_CTRL, 32'(ctl[i]));
      repeat (600) @(posedge clk);
      repeat (i < 3 ? 256 : 510) begin
        @(posedge clk);
        if (compareOutputA === 1'b1) n++;
      end
      apb(1'b1, ADDR_CTRL, '0);
      check(32'(n >= lo[i] && n <= hi[i]), 32'h1);
    end
  endtask : t_pwm
  initial begin
    #2ms;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_prescale();
    t_ext();
    t_force();
    t_irq();
    t_pwm();
    report_and_stop();
  end
endmodule : test_timer8_compare_output_control

// ### sim/tmr_pin_model.sv
// Pin-side model: external count pulses and the resolved compare pin
module tmr_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  input wire logic compareOutputA,
  input wire logic compareOutputAOe_n,
  output logic externalCountInput,
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastLevel = 1'b0;
  initial externalCountInput = 1'b0;
  always_ff @(posedge clk) if (!compareOutputAOe_n) lastLevel <= compareOutputA;
  // released pin shows the inverse of the last driven level
  assign pinLevel = compareOutputAOe_n ? ~lastLevel : compareOutputA;
  task automatic pulse();
    repeat (3) @(posedge clk);
    externalCountInput <= 1'b1;
    repeat (3) @(posedge clk);
    externalCountInput <= 1'b0;
  endtask : pulse
endmodule : tmr_pin_model

// ### sim/tmr_timer8_sva.sv
// Port assertions for the 8-bit compare timer
module tmr_timer8_sva
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic globalIrqEnable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic rdDone = pready && !pwrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_access; pready |-> psel && penable && $past(psel && !penable); endproperty
  a_access: assert property (p_access) else $error("answer outside access");
  property p_err; pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > ADDR_PINCFG); endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_errdata; pready && pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
  a_errdata: assert property (p_errdata) else $error("refused read not zero");
  property p_upper; rdDone |-> prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_force; rdDone && paddr == ADDR_CTRL |-> !prdata[CTRL_FORCE]; endproperty
  a_force: assert property (p_force) else $error("force bit read as one");
  property p_flags; rdDone && paddr == ADDR_FLAGS |-> prdata[7:2] == 6'h00; endproperty
  a_flags: assert property (p_flags) else $error("spare flag bits set");
  property p_irq; irq |-> $past(globalIrqEnable); endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
endmodule : tmr_timer8_sva
bind tmr_timer8 tmr_timer8_sva chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .globalIrqEnable(globalIrqEnable), .irq(irq));
